// *** design/ctrl_port_defines.svh ***
// Constants for the two-wire slave control port
`ifndef CTRL_PORT_DEFINES_SVH
`define CTRL_PORT_DEFINES_SVH

`define CHIP_ADDR_FIXED  5'h0d
`define MAX_WORD_BYTES   3'h5
`define SUBADDR_HIGHEST  16'h0fff
`define BOOT_SAMPLE_CYC  2'h3
`define BITS_PER_BYTE    4'h8
`define LAST_BIT_IDX     4'h7

`endif

// *** design/ctrl_port_pkg.sv ***
// Types for the two-wire slave control port
package ctrl_port_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RECV,
        ST_SACK,
        ST_SEND,
        ST_MACK
    } port_state_t;

    typedef enum logic [1:0] {
        PH_CHIP,
        PH_SUBH,
        PH_SUBL,
        PH_DATA
    } byte_phase_t;

endpackage

// *** design/i2c_slave_control_port.sv ***
// Two-wire slave control port with burst access to internal words
`timescale 1ns/100ps
`default_nettype none
`include "ctrl_port_defines.svh"

module i2c_slave_control_port
    import ctrl_port_pkg::*;
#(
    parameter int          ADDR_W      = 16,
    parameter int          WORD_W      = 40,
    parameter logic [15:0] HIGHEST_SUB = `SUBADDR_HIGHEST
) (
    input  wire logic              i_mclk,
    input  wire logic              i_rst,
    input  wire logic              i_scl,
    input  wire logic              i_sda,
    input  wire logic              i_chip_address_strap_a,
    input  wire logic              i_chip_address_strap_b,
    input  wire logic              i_boot_select,
    input  wire logic [2:0]        i_word_len,
    input  wire logic              i_addr_ok,
    input  wire logic [WORD_W-1:0] i_rd_data,
    input  wire logic              i_wr_ready,
    output logic                   o_sda_out,
    output logic                   o_sda_oe_n,
    output logic [ADDR_W-1:0]      o_addr,
    output logic                   o_wr_valid,
    output logic [ADDR_W-1:0]      o_wr_addr,
    output logic [WORD_W-1:0]      o_wr_data,
    output logic [2:0]             o_wr_len,
    output logic                   o_mode_active
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] pin_raw;
    logic [4:0] meta_reg;
    logic [4:0] sync_reg;
    logic       scl_d_reg;
    logic       sda_d_reg;

    assign pin_raw = {i_boot_select, i_chip_address_strap_b,
                      i_chip_address_strap_a, i_sda, i_scl};

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            meta_reg <= 5'h03;
            sync_reg <= 5'h03;
        end else begin
            meta_reg <= pin_raw;
            sync_reg <= meta_reg;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= sync_reg[0];
            sda_d_reg <= sync_reg[1];
        end
    end

    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    assign scl_s      = sync_reg[0];
    assign sda_s      = sync_reg[1];
    assign scl_rise   = scl_s & ~scl_d_reg;
    assign scl_fall   = ~scl_s & scl_d_reg;
    assign start_seen = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_seen  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // ------------------------------------------------------------
    // Boot mode capture after reset
    // ------------------------------------------------------------
    logic [1:0] boot_cnt_reg;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            boot_cnt_reg  <= 2'h0;
            o_mode_active <= 1'b0;
        end else if (boot_cnt_reg != `BOOT_SAMPLE_CYC) begin
            boot_cnt_reg <= boot_cnt_reg + 2'h1;
            if (boot_cnt_reg == `BOOT_SAMPLE_CYC - 2'h1) begin
                o_mode_active <= ~sync_reg[4];
            end
        end
    end

    // ------------------------------------------------------------
    // Word length and read byte selection
    // ------------------------------------------------------------
    logic [2:0] word_len;
    logic [2:0] byte_idx_reg;
    logic [2:0] rd_sel;
    logic [7:0] rd_byte;
    logic       word_last;
    logic [6:0] own_addr;

    always_comb begin
        word_len = i_word_len;
        if (i_word_len == 3'h0 || i_word_len > `MAX_WORD_BYTES) begin
            word_len = 3'h1;
        end
    end

    assign word_last = (byte_idx_reg + 3'h1) >= word_len;

    always_comb begin
        rd_sel = word_len - 3'h1 - byte_idx_reg;
        if (byte_idx_reg >= word_len) begin
            rd_sel = 3'h0;
        end
        rd_byte = i_rd_data[8*rd_sel +: 8];
    end

    assign own_addr = {`CHIP_ADDR_FIXED, sync_reg[2], sync_reg[3]};

    // ------------------------------------------------------------
    // Serial protocol engine
    // ------------------------------------------------------------
    port_state_t state_reg;
    byte_phase_t phase_reg;
    logic [3:0]  bit_cnt_reg;
    logic [7:0]  rx_reg;
    logic [7:0]  tx_reg;
    logic        read_dir_reg;
    logic        over_reg;
    logic [31:0] wbuf_reg;
    logic        push_reg;
    logic [ADDR_W-1:0] push_addr_reg;
    logic [WORD_W-1:0] push_data_reg;
    logic [2:0]  push_len_reg;
    logic        skid_valid_reg;
    logic [7:0]  rx_byte;

    assign rx_byte = rx_reg;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state_reg     <= ST_IDLE;
            phase_reg     <= PH_CHIP;
            bit_cnt_reg   <= 4'h0;
            rx_reg        <= 8'h00;
            tx_reg        <= 8'h00;
            read_dir_reg  <= 1'b0;
            over_reg      <= 1'b0;
            wbuf_reg      <= 32'h0;
            byte_idx_reg  <= 3'h0;
            o_addr        <= '0;
            o_sda_oe_n    <= 1'b1;
            o_sda_out     <= 1'b0;
            push_reg      <= 1'b0;
            push_addr_reg <= '0;
            push_data_reg <= '0;
            push_len_reg  <= 3'h0;
        end else begin
            push_reg <= 1'b0;
            if (!o_mode_active) begin
                state_reg  <= ST_IDLE;
                o_sda_oe_n <= 1'b1;
            end else if (stop_seen) begin
                state_reg  <= ST_IDLE;
                o_sda_oe_n <= 1'b1;
            end else if (start_seen) begin
                state_reg   <= ST_RECV;
                phase_reg   <= PH_CHIP;
                bit_cnt_reg <= 4'h0;
                o_sda_oe_n  <= 1'b1;
            end else begin
                case (state_reg)
                    ST_RECV: begin
                        if (scl_rise && bit_cnt_reg != `BITS_PER_BYTE) begin
                            rx_reg      <= {rx_reg[6:0], sda_s};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            if (bit_cnt_reg == `LAST_BIT_IDX) begin
                                if (phase_reg == PH_SUBH) begin
                                    o_addr[15:8] <= {rx_reg[6:0], sda_s};
                                end
                                if (phase_reg == PH_SUBL) begin
                                    o_addr[7:0] <= {rx_reg[6:0], sda_s};
                                end
                            end
                        end else if (scl_fall && bit_cnt_reg == `BITS_PER_BYTE) begin
                            bit_cnt_reg <= 4'h0;
                            state_reg   <= ST_SACK;
                            o_sda_oe_n  <= 1'b0;
                            case (phase_reg)
                                PH_CHIP: begin
                                    if (rx_byte[7:1] != own_addr) begin
                                        state_reg  <= ST_IDLE;
                                        o_sda_oe_n <= 1'b1;
                                    end else begin
                                        read_dir_reg <= rx_byte[0];
                                        byte_idx_reg <= 3'h0;
                                        phase_reg    <= rx_byte[0] ? PH_DATA
                                                                   : PH_SUBH;
                                    end
                                end
                                PH_SUBH: begin
                                    phase_reg <= PH_SUBL;
                                end
                                PH_SUBL: begin
                                    if (!i_addr_ok) begin
                                        state_reg  <= ST_IDLE;
                                        o_sda_oe_n <= 1'b1;
                                    end else begin
                                        phase_reg    <= PH_DATA;
                                        over_reg     <= 1'b0;
                                        byte_idx_reg <= 3'h0;
                                        wbuf_reg     <= 32'h0;
                                    end
                                end
                                default: begin
                                    if (over_reg || (word_last && skid_valid_reg)) begin
                                        state_reg  <= ST_IDLE;
                                        o_sda_oe_n <= 1'b1;
                                    end else if (word_last) begin
                                        push_reg      <= 1'b1;
                                        push_addr_reg <= o_addr;
                                        push_data_reg <= WORD_W'({wbuf_reg, rx_byte});
                                        push_len_reg  <= word_len;
                                        wbuf_reg      <= 32'h0;
                                        byte_idx_reg  <= 3'h0;
                                        if (o_addr == HIGHEST_SUB) begin
                                            over_reg <= 1'b1;
                                        end else begin
                                            o_addr <= o_addr + 1'b1;
                                        end
                                    end else begin
                                        wbuf_reg     <= {wbuf_reg[23:0], rx_byte};
                                        byte_idx_reg <= byte_idx_reg + 3'h1;
                                    end
                                end
                            endcase
                        end
                    end
                    ST_SACK: begin
                        if (scl_fall) begin
                            if (read_dir_reg && phase_reg == PH_DATA) begin
                                state_reg   <= ST_SEND;
                                tx_reg      <= rd_byte;
                                o_sda_oe_n  <= rd_byte[7];
                                bit_cnt_reg <= 4'h0;
                            end else begin
                                state_reg  <= ST_RECV;
                                o_sda_oe_n <= 1'b1;
                            end
                        end
                    end
                    ST_SEND: begin
                        if (scl_fall) begin
                            if (bit_cnt_reg == `LAST_BIT_IDX) begin
                                state_reg   <= ST_MACK;
                                bit_cnt_reg <= 4'h0;
                                o_sda_oe_n  <= 1'b1;
                            end else begin
                                tx_reg      <= {tx_reg[6:0], 1'b0};
                                o_sda_oe_n  <= tx_reg[6];
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise && bit_cnt_reg == 4'h0) begin
                            if (sda_s) begin
                                state_reg <= ST_IDLE;
                            end else begin
                                bit_cnt_reg <= `BITS_PER_BYTE;
                                if (word_last) begin
                                    byte_idx_reg <= 3'h0;
                                    if (o_addr != HIGHEST_SUB) begin
                                        o_addr <= o_addr + 1'b1;
                                    end
                                end else begin
                                    byte_idx_reg <= byte_idx_reg + 3'h1;
                                end
                            end
                        end else if (scl_fall && bit_cnt_reg == `BITS_PER_BYTE) begin
                            state_reg   <= ST_SEND;
                            tx_reg      <= rd_byte;
                            o_sda_oe_n  <= rd_byte[7];
                            bit_cnt_reg <= 4'h0;
                        end
                    end
                    default: begin
                        state_reg  <= ST_IDLE;
                        o_sda_oe_n <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Two-entry write word buffer
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] skid_addr_reg;
    logic [WORD_W-1:0] skid_data_reg;
    logic [2:0]        skid_len_reg;
    logic              pop;

    assign pop = o_wr_valid & i_wr_ready;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_wr_valid     <= 1'b0;
            o_wr_addr      <= '0;
            o_wr_data      <= '0;
            o_wr_len       <= 3'h0;
            skid_valid_reg <= 1'b0;
            skid_addr_reg  <= '0;
            skid_data_reg  <= '0;
            skid_len_reg   <= 3'h0;
        end else if (skid_valid_reg) begin
            if (pop) begin
                o_wr_addr      <= skid_addr_reg;
                o_wr_data      <= skid_data_reg;
                o_wr_len       <= skid_len_reg;
                skid_valid_reg <= 1'b0;
            end
        end else if (push_reg) begin
            if (!o_wr_valid || pop) begin
                o_wr_valid <= 1'b1;
                o_wr_addr  <= push_addr_reg;
                o_wr_data  <= push_data_reg;
                o_wr_len   <= push_len_reg;
            end else begin
                skid_valid_reg <= 1'b1;
                skid_addr_reg  <= push_addr_reg;
                skid_data_reg  <= push_data_reg;
                skid_len_reg   <= push_len_reg;
            end
        end else if (pop) begin
            o_wr_valid <= 1'b0;
        end
    end

endmodule // i2c_slave_control_port
`default_nettype wire

// *** verif/bus_master_model.sv ***
// Behavioural bus master driving serial clock and data
`timescale 1ns/100ps
`default_nettype none
module bus_master_model (
    input  wire logic i_mclk,
    input  wire logic i_sda_bus,
    output var logic  o_scl,
    output var logic  o_sda
);
    // Both lines idle released high
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    task automatic w(input int n);
        repeat (n) @(posedge i_mclk);
    endtask

    // One 160 ns slot: data set mid-low, sampled mid-high
    task automatic bit_io(input logic b, output logic r);
        o_sda <= b;
        w(2);
        o_scl <= 1'b1;
        w(2);
        r = i_sda_bus;
        w(2);
        o_scl <= 1'b0;
        w(2);
    endtask

    task automatic start();
        o_sda <= 1'b1;
        w(2);
        o_scl <= 1'b1;
        w(2);
        o_sda <= 1'b0;
        w(2);
        o_scl <= 1'b0;
        w(2);
    endtask

    task automatic stop();
        o_sda <= 1'b0;
        w(2);
        o_scl <= 1'b1;
        w(2);
        o_sda <= 1'b1;
        w(4);
    endtask

    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask

    task automatic recv(input logic give, output logic [7:0] b);
        logic r;
        for (int i = 0; i < 8; i++) begin
            bit_io(1'b1, r);
            b = {b[6:0], r};
        end
        bit_io(!give, r);
    endtask
endmodule // bus_master_model
`default_nettype wire

// *** verif/ctrl_port_monitor.sv ***
// Concurrent checks on the two-wire slave control port
`timescale 1ns/100ps
`default_nettype none
module ctrl_port_monitor #(
    parameter int          ADDR_W      = 16,
    parameter int          WORD_W      = 40,
    parameter logic [15:0] HIGHEST_SUB = 16'h0fff
) (
    input wire logic              i_mclk,
    input wire logic              i_rst,
    input wire logic              i_scl,
    input wire logic              i_sda,
    input wire logic              i_boot_select,
    input wire logic              i_wr_ready,
    input wire logic              o_sda_out,
    input wire logic              o_sda_oe_n,
    input wire logic              o_wr_valid,
    input wire logic [ADDR_W-1:0] o_wr_addr,
    input wire logic [WORD_W-1:0] o_wr_data,
    input wire logic [2:0]        o_wr_len,
    input wire logic              o_mode_active
);
    // ------------------------------
    // Cycles since serial clock fell
    // ------------------------------
    logic [3:0] fall_age_reg;

    always_ff @(posedge i_mclk) begin
        if (i_rst || $fell(i_scl))
            fall_age_reg <= 4'h0;
        else if (fall_age_reg != 4'hf)
            fall_age_reg <= fall_age_reg + 4'h1;
    end

    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    AST_MODE_LOW: assert property (
        o_mode_active |-> !i_boot_select)
        else $error("port enabled while boot select high");
    AST_IDLE_QUIET: assert property (
        !o_mode_active |-> o_sda_oe_n)
        else $error("bus driven while port disabled");
    AST_DRIVE_ZERO: assert property (
        !o_sda_oe_n |-> o_sda_out == 1'b0)
        else $error("bus driven high");
    AST_DRIVE_TIME: assert property (
        $changed(o_sda_oe_n) |-> fall_age_reg inside {[4'h1:4'h6]})
        else $error("bus drive changed outside clock low phase");
    AST_STOP_QUIET: assert property (
        i_scl && $past(i_scl) && $rose(i_sda) |=> o_sda_oe_n [*8])
        else $error("bus driven after stop");
    AST_WR_HOLD: assert property (
        o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr_addr)
            && $stable(o_wr_data) && $stable(o_wr_len))
        else $error("pending word changed before taken");
    AST_WR_LEN: assert property (
        o_wr_valid |-> o_wr_len inside {[3'h1:3'h5]})
        else $error("word length out of range");
    AST_WR_RANGE: assert property (
        o_wr_valid |-> o_wr_addr <= HIGHEST_SUB)
        else $error("word written past highest location");

endmodule // ctrl_port_monitor

bind i2c_slave_control_port ctrl_port_monitor #(
    .ADDR_W(ADDR_W), .WORD_W(WORD_W), .HIGHEST_SUB(HIGHEST_SUB)
) mon_u (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda),
    .i_boot_select(i_boot_select), .i_wr_ready(i_wr_ready),
    .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n),
    .o_wr_valid(o_wr_valid), .o_wr_addr(o_wr_addr),
    .o_wr_data(o_wr_data), .o_wr_len(o_wr_len),
    .o_mode_active(o_mode_active)
);
`default_nettype wire

// *** verif/i2c_slave_control_port_tb.sv ***
// Self-checking bench for the two-wire slave control port
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_control_port_tb;
    localparam logic [15:0] HI = 16'h0101;
    logic        mclk  = 1'b0;
    logic        rst   = 1'b1;
    logic        boot  = 1'b0;
    logic        ready = 1'b0;
    logic        aok   = 1'b1;
    logic [2:0]  wlen  = 3'h1;
    logic [39:0] rdat  = 40'h0;
    logic        scl, m_sda, sda_bus, sda_o, oe_n, wv, mode;
    logic [15:0] addr, waddr;
    logic [39:0] wdat;
    logic [2:0]  wl;
    int          mismatches = 0;
    int          check_count = 0;
    int          took = 0;

    always #10 mclk = ~mclk;
    assign sda_bus = m_sda & (oe_n | sda_o);

    // Word lengths: upper page 2, address bit 2 set five, else 1 to 4
    function automatic logic [2:0] len_of(input logic [15:0] a);
        if (a[15:8] != 8'h00)
            return 3'h2;
        return a[2] ? 3'h5 : {1'b0, a[1:0]} + 3'h1;
    endfunction

    always @(posedge mclk) begin
        wlen <= len_of(addr);
        aok  <= addr <= HI;
        rdat <= {8'h00, addr ^ 16'h5a5a, addr};
        if (wv && ready)
            took <= took + 1;
    end

    bus_master_model mst_u (.i_mclk(mclk), .i_sda_bus(sda_bus),
        .o_scl(scl), .o_sda(m_sda));
    i2c_slave_control_port #(.HIGHEST_SUB(HI)) dut_u (
        .i_mclk(mclk), .i_rst(rst), .i_scl(scl), .i_sda(sda_bus),
        .i_chip_address_strap_a(1'b1), .i_chip_address_strap_b(1'b0),
        .i_boot_select(boot), .i_word_len(wlen), .i_addr_ok(aok),
        .i_rd_data(rdat), .i_wr_ready(ready), .o_sda_out(sda_o),
        .o_sda_oe_n(oe_n), .o_addr(addr), .o_wr_valid(wv),
        .o_wr_addr(waddr), .o_wr_data(wdat), .o_wr_len(wl),
        .o_mode_active(mode));

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        if (mismatches == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic hdr(input logic [15:0] sub, output logic [2:0] a);
        mst_u.start();
        mst_u.send(8'h6c, a[2]);
        mst_u.send(sub[15:8], a[1]);
        mst_u.send(sub[7:0], a[0]);
    endtask

    task automatic drain(input logic [59:0] exp);
        #1 chk({wv, waddr, wl, wdat}, exp);
        @(posedge mclk);
        ready <= 1'b1;
        @(posedge mclk);
        ready <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    task automatic t_reset();
        repeat (4) @(posedge mclk);
        #1 chk({oe_n, wv, mode, addr}, {3'b100, 16'h0});
        @(posedge mclk);
        rst <= 1'b0;
        repeat (8) @(posedge mclk);
        #1 chk(mode, 1'b1);
        @(posedge mclk);
    endtask

    task automatic t_addr();
        logic a;
        for (int i = 0; i < 4; i++) begin
            mst_u.start();
            mst_u.send({5'h0d, i[1:0], 1'b0}, a);
            mst_u.stop();
            chk(a, i == 2);
        end
    endtask

    task automatic t_burst();
        logic [2:0]  a;
        logic [11:0] k;
        hdr(16'h0002, a);
        for (int j = 0; j < 12; j++) mst_u.send(8'h10 + j[7:0], k[11 - j]);
        mst_u.stop();
        chk({a, k}, 15'h7ffe);
        drain({1'b1, 16'h0002, 3'h3, 40'h101112});
        drain({1'b1, 16'h0003, 3'h4, 40'h13141516});
        #1 chk(wv, 1'b0);
    endtask

    task automatic t_partial();
        logic [2:0] a;
        logic       b;
        int         n;
        @(posedge mclk);
        n = took;
        ready <= 1'b1;
        hdr(16'h0001, a);
        mst_u.send(8'haa, b);
        repeat (4) mst_u.bit_io(1'b1, b);
        mst_u.start();
        mst_u.send(8'h6c, b);
        mst_u.stop();
        chk(b, 1'b1);
        chk(took - n, 0);
        ready <= 1'b0;
    endtask

    task automatic t_badsub();
        logic [2:0] a;
        hdr(16'h0200, a);
        mst_u.stop();
        chk(a, 3'b110);
    endtask

    task automatic t_read();
        logic [2:0]  a;
        logic        b;
        logic [47:0] q;
        hdr(16'h0100, a);
        mst_u.start();
        mst_u.send(8'h6d, b);
        for (int j = 0; j < 6; j++) mst_u.recv(j < 5, q[47 - 8 * j -: 8]);
        mst_u.stop();
        chk({a, b}, 4'hf);
        chk(q, 48'h0100_0101_0101);
        chk(addr, HI);
    endtask

    task automatic t_over();
        logic [2:0] a;
        logic [2:0] k;
        hdr(HI, a);
        mst_u.send(8'hde, k[2]);
        mst_u.send(8'had, k[1]);
        mst_u.send(8'hbe, k[0]);
        mst_u.stop();
        chk({a, k}, 6'b111110);
        drain({1'b1, HI, 3'h2, 40'hdead});
        #1 chk(wv, 1'b0);
    endtask

    // Mid-run reset with boot select high: port stays off
    task automatic t_boot();
        logic a;
        @(posedge mclk);
        rst  <= 1'b1;
        boot <= 1'b1;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1 chk({oe_n, wv, mode, addr}, {3'b100, 16'h0});
        repeat (8) @(posedge mclk);
        #1 chk(mode, 1'b0);
        @(posedge mclk);
        mst_u.start();
        mst_u.send(8'h6c, a);
        mst_u.stop();
        chk(a, 1'b0);
    endtask

    initial begin
        t_reset();
        t_addr();
        t_burst();
        t_partial();
        t_badsub();
        t_read();
        t_over();
        t_boot();
        wrap_up();
    end

    initial begin
        repeat (100000) @(posedge mclk);
        mismatches++;
        wrap_up();
    end
endmodule // i2c_slave_control_port_tb
`default_nettype wire
